// ===== include/gdf_pkg.sv
// Package of constants and types for the gate driver fault feedback block
package gdf_pkg;

    // ==================================================================
    // Clock and timing
    // ==================================================================
    localparam int CLK_FREQ_HZ     = 25_000_000;
    localparam int CLK_PERIOD_NS   = 40;
    localparam int ACK_PULSE_NS    = 900;
    localparam int SC_SAMPLE_NS    = 8500;
    localparam int SC_DEADLINE_NS  = 10000;
    localparam int FAULT_HOLD_MS   = 1000;
    // Acknowledge pulse: about 900 ns, rounded down
    localparam int ACK_CYCLES      = ACK_PULSE_NS / CLK_PERIOD_NS;
    // Comparator sample point after turn-on, rounded down
    localparam int SC_SAMPLE_CYCLES = SC_SAMPLE_NS / CLK_PERIOD_NS;
    // Latest turn-off after turn-on, rounded down
    localparam int SC_DEADLINE_CYCLES = SC_DEADLINE_NS / CLK_PERIOD_NS;
    // Fault hold, one second
    localparam int FAULT_HOLD_CYCLES = (CLK_FREQ_HZ / 1000) * FAULT_HOLD_MS;

    localparam int TMR_W  = 9;
    localparam int HOLD_W = 25;

    // ==================================================================
    // Mode jumper encoding: 1-2 bridged reads 0, 2-3 bridged reads 1
    // ==================================================================
    localparam logic JUMPER_TWO_LEVEL   = 1'h0;
    localparam logic JUMPER_MULTI_LEVEL = 1'h1;

    typedef enum logic {GDF_MODE_TWO_LEVEL, GDF_MODE_MULTI_LEVEL} gdf_mode_t;

    // Synchronised pin inputs
    typedef struct packed {
        logic cmd_light;
        logic sc_comp;
        logic uvlo;
        logic jumper;
    } gdf_pins_t;

endpackage : gdf_pkg

// ===== src/gdf_sync.sv
// Two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ns
module gdf_sync
    import gdf_pkg::*;
#(
    parameter int W = 4
)(
    input  wire logic         clk_sys_in,
    input  wire logic         rstn_in,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] stage1;
    logic [W-1:0] next_stage1;
    logic [W-1:0] next_sync;

    // ==================================================================
    // Next values: first stage feeds only the second
    // ==================================================================
    always_comb
    begin
        next_stage1 = async_in;
        next_sync   = stage1;
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            stage1   <= '0;
            sync_out <= '0;
        end
        else
        begin
            stage1   <= next_stage1;
            sync_out <= next_sync;
        end
    end

endmodule : gdf_sync

// ===== src/gdf_core.sv
// Gate driver command, short-circuit response and status feedback logic
`timescale 1ns/1ns
module gdf_core
    import gdf_pkg::*;
#(
    parameter int HOLD_CYCLES = FAULT_HOLD_CYCLES
)(
    input  wire logic clk_sys_in,
    input  wire logic rstn_in,
    input  wire logic cmd_light_in,
    input  wire logic sc_comp_in,
    input  wire logic uvlo_in,
    input  wire logic mode_select_jumper_in,
    output logic      gate_on_out,
    output logic      status_light_out,
    output logic      fault_active_out,
    output logic      mode_multi_out
);

    // ==================================================================
    // Pin synchronisation
    // ==================================================================
    gdf_pins_t pins;
    logic [3:0] pins_raw;
    logic [3:0] pins_sync;

    assign pins_raw = {cmd_light_in, sc_comp_in, uvlo_in, mode_select_jumper_in};
    assign pins     = gdf_pins_t'(pins_sync);

    gdf_sync #(.W(4)) u_sync (
        .clk_sys_in (clk_sys_in),
        .rstn_in    (rstn_in),
        .async_in   (pins_raw),
        .sync_out   (pins_sync)
    );

    // ==================================================================
    // State
    // ==================================================================
    gdf_mode_t         mode;
    logic              cmd_prev;
    logic [TMR_W-1:0]  on_tmr;
    logic              sampled;
    logic              sc_lock;
    logic [HOLD_W-1:0] hold_cnt;
    logic [4:0]        ack_cnt;
    logic              gate;
    logic              status;

    gdf_mode_t         next_mode;
    logic              next_cmd_prev;
    logic [TMR_W-1:0]  next_on_tmr;
    logic              next_sampled;
    logic              next_sc_lock;
    logic [HOLD_W-1:0] next_hold_cnt;
    logic [4:0]        next_ack_cnt;
    logic              next_gate;
    logic              next_status;
    logic              edge_seen;
    logic              sc_detect;

    // ==================================================================
    // Next-state logic
    // ==================================================================
    always_comb
    begin
        // Mode follows the jumper; no latch so a moved jumper acts at once
        next_mode = (pins.jumper == JUMPER_MULTI_LEVEL) ? GDF_MODE_MULTI_LEVEL
                                                         : GDF_MODE_TWO_LEVEL;
        next_cmd_prev = pins.cmd_light;
        edge_seen     = pins.cmd_light ^ cmd_prev;

        // On-time timer restarts at every turn-on command
        next_on_tmr  = on_tmr;
        next_sampled = sampled;
        if (pins.cmd_light && !cmd_prev)
        begin
            next_on_tmr  = '0;
            next_sampled = 1'b0;
        end
        else if (pins.cmd_light && on_tmr != TMR_W'(SC_DEADLINE_CYCLES))
        begin
            next_on_tmr = on_tmr + TMR_W'(1);
        end

        // Single comparator look per turn-on, at the sample point
        sc_detect = pins.cmd_light && !sampled
                    && on_tmr == TMR_W'(SC_SAMPLE_CYCLES - 1) && pins.sc_comp;
        if (pins.cmd_light && on_tmr == TMR_W'(SC_SAMPLE_CYCLES - 1))
        begin
            next_sampled = 1'b1;
        end

        // Fault hold counter; a fresh detection restarts the hold
        next_sc_lock  = sc_lock;
        next_hold_cnt = hold_cnt;
        if (sc_detect)
        begin
            next_sc_lock  = 1'b1;
            next_hold_cnt = '0;
        end
        else if (sc_lock)
        begin
            if (hold_cnt == HOLD_W'(HOLD_CYCLES - 1))
            begin
                next_sc_lock = 1'b0;
            end
            else
            begin
                next_hold_cnt = hold_cnt + HOLD_W'(1);
            end
        end

        // Edge acknowledge pulse counter
        next_ack_cnt = ack_cnt;
        if (edge_seen)
        begin
            next_ack_cnt = 5'(ACK_CYCLES);
        end
        else if (ack_cnt != 5'h00)
        begin
            next_ack_cnt = ack_cnt - 5'h01;
        end

        // Gate command
        next_gate = pins.cmd_light;
        if (pins.uvlo)
        begin
            next_gate = 1'b0;
        end
        else if (next_mode == GDF_MODE_TWO_LEVEL && (sc_detect || sc_lock))
        begin
            // Two-level: local turn-off, ignoring command until hold ends
            next_gate = 1'b0;
        end
        // Multilevel leaves the gate on the command; host sequences turn-off

        // Feedback light: healthy and no pulse in progress
        next_status = !pins.uvlo && !sc_lock && !sc_detect
                      && !edge_seen && ack_cnt <= 5'h01;
    end

    // ==================================================================
    // Registers
    // ==================================================================
    always_ff @(posedge clk_sys_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            mode     <= GDF_MODE_TWO_LEVEL;
            cmd_prev <= 1'b0;
            on_tmr   <= '0;
            sampled  <= 1'b1;
            sc_lock  <= 1'b0;
            hold_cnt <= '0;
            ack_cnt  <= 5'h00;
            gate     <= 1'b0;
            status   <= 1'b0;
        end
        else
        begin
            mode     <= next_mode;
            cmd_prev <= next_cmd_prev;
            on_tmr   <= next_on_tmr;
            sampled  <= next_sampled;
            sc_lock  <= next_sc_lock;
            hold_cnt <= next_hold_cnt;
            ack_cnt  <= next_ack_cnt;
            gate     <= next_gate;
            status   <= next_status;
        end
    end

    assign gate_on_out      = gate;
    assign status_light_out = status;
    assign fault_active_out = sc_lock;
    assign mode_multi_out   = (mode == GDF_MODE_MULTI_LEVEL);

    // ==================================================================
    // Assertions
    // ==================================================================
    property p_two_level_off;
        @(posedge clk_sys_in) disable iff (!rstn_in)
        (sc_lock && mode == GDF_MODE_TWO_LEVEL && $past(mode) == GDF_MODE_TWO_LEVEL) |-> !gate;
    endproperty
    a_two_level_off: assert property (p_two_level_off)
        else $error("gate on during two-level fault");

    property p_multi_follow;
        @(posedge clk_sys_in) disable iff (!rstn_in)
        (mode == GDF_MODE_MULTI_LEVEL && next_mode == GDF_MODE_MULTI_LEVEL && !pins.uvlo)
        |=> gate == $past(pins.cmd_light);
    endproperty
    a_multi_follow: assert property (p_multi_follow)
        else $error("gate not following command in multilevel mode");

    property p_mode_jumper;
        @(posedge clk_sys_in) disable iff (!rstn_in)
        ##1 (mode == GDF_MODE_MULTI_LEVEL) == $past(pins.jumper);
    endproperty
    a_mode_jumper: assert property (p_mode_jumper)
        else $error("mode does not match jumper");

    property p_fault_dark;
        @(posedge clk_sys_in) disable iff (!rstn_in)
        (sc_lock || pins.uvlo) |=> !status;
    endproperty
    a_fault_dark: assert property (p_fault_dark)
        else $error("light on during malfunction");

    property p_ack_pulse;
        @(posedge clk_sys_in) disable iff (!rstn_in)
        edge_seen |=> !status [*8];
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("acknowledge pulse too short");

    // Cycles left between the comparator look and the turn-off deadline;
    // three cycles of the pin-to-timer latency are already spent
    localparam int DL_SLACK = SC_DEADLINE_CYCLES - SC_SAMPLE_CYCLES - 3;

    // The on-time timer stands in for a long repetition: once it reaches the
    // sample point with the comparator high in two-level mode, the gate must drop before the deadline
    property p_deadline;
        @(posedge clk_sys_in) disable iff (!rstn_in)
        (pins.cmd_light && !sampled && on_tmr == TMR_W'(SC_SAMPLE_CYCLES - 1)
         && pins.sc_comp && next_mode == GDF_MODE_TWO_LEVEL)
        |-> ##[1:DL_SLACK] !gate;
    endproperty
    a_deadline: assert property (p_deadline)
        else $error("switch not off by deadline");

    property p_hold_start;
        @(posedge clk_sys_in) disable iff (!rstn_in)
        sc_detect |=> sc_lock && hold_cnt == '0;
    endproperty
    a_hold_start: assert property (p_hold_start)
        else $error("fault hold not started");

    property p_uvlo_off;
        @(posedge clk_sys_in) disable iff (!rstn_in)
        pins.uvlo |=> !gate;
    endproperty
    a_uvlo_off: assert property (p_uvlo_off)
        else $error("gate on under undervoltage");

    c_ack: cover property (@(posedge clk_sys_in) disable iff (!rstn_in) edge_seen ##1 !status);
    c_sc_two: cover property (@(posedge clk_sys_in) disable iff (!rstn_in)
        sc_detect && mode == GDF_MODE_TWO_LEVEL);
    c_sc_multi: cover property (@(posedge clk_sys_in) disable iff (!rstn_in)
        sc_detect && mode == GDF_MODE_MULTI_LEVEL);
    c_hold_end: cover property (@(posedge clk_sys_in) disable iff (!rstn_in) $fell(sc_lock));

endmodule : gdf_core

// ===== test/gdf_host_model.sv
// Host controller model: drives the optical command and watches the feedback
`timescale 1ns/1ns
module gdf_host_model
    import gdf_pkg::*;
(
    input  wire logic       clk_sys_in,
    input  wire logic       rstn_in,
    input  wire logic       cmd_req_in,
    input  wire logic       status_light_in,
    output logic            cmd_light_out,
    output logic      [7:0] ack_count_out
);
    logic status_prev;

    // ==========================================
    // Command link
    // ==========================================
    // Light follows the host request; in multilevel mode the host alone sequences turn-off
    assign cmd_light_out = cmd_req_in;

    // ==========================================
    // Feedback watch
    // ==========================================
    // Every light-off edge is counted, so a silent or broken link shows as a missing count
    always_ff @(posedge clk_sys_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            status_prev   <= 1'b0;
            ack_count_out <= 8'h00;
        end
        else
        begin
            status_prev <= status_light_in;
            if (status_prev && !status_light_in)
                ack_count_out <= ack_count_out + 8'h01;
        end
    end
endmodule : gdf_host_model

// ===== test/gate_driver_fault_feedback_tb.sv
// Self-checking testbench for the gate driver fault feedback block
`timescale 1ns/1ns
module gate_driver_fault_feedback_tb;
    import gdf_pkg::*;
    localparam int HOLD  = 500;   // Short fault hold keeps the run brief
    localparam int LIMIT = 20000;
    logic       clk_sys_in = 1'b0;
    logic       rstn_in    = 1'b0;
    logic       cmd_req    = 1'b0;
    logic       sc_comp    = 1'b0;
    logic       uvlo       = 1'b0;
    logic       jumper     = 1'b0;
    logic       cmd_light;
    logic       gate_on;
    logic       status;
    logic       fault;
    logic       multi;
    logic [7:0] acks;
    int         err_total  = 0;
    int         n_compared = 0;
    int         cycles     = 0;

    // ==========================================
    // Clock, partner and design
    // ==========================================
    initial forever #20 clk_sys_in = ~clk_sys_in;

    gdf_host_model HOST (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .cmd_req_in(cmd_req),
        .status_light_in(status), .cmd_light_out(cmd_light), .ack_count_out(acks));
    gdf_core #(.HOLD_CYCLES(HOLD)) DUT (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
        .cmd_light_in(cmd_light), .sc_comp_in(sc_comp), .uvlo_in(uvlo),
        .mode_select_jumper_in(jumper), .gate_on_out(gate_on), .status_light_out(status),
        .fault_active_out(fault), .mode_multi_out(multi));

    // ==========================================
    // Helpers
    // ==========================================
    task chk(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1)
        begin
            err_total++;
            $display("[FAIL] %0t ns %s", $time, msg);
        end
    endtask : chk

    // Inputs always change 1 ns after the rising edge
    task cyc(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask : cyc

    // Waits for the light-off acknowledge and measures its length in cycles
    task dark(output int n);
        int w;
        w = 0;
        n = 0;
        while (status !== 1'b0 && w < 8)
        begin
            cyc(1);
            w++;
        end
        while (status === 1'b0 && n < 4000)
        begin
            cyc(1);
            n++;
        end
    endtask : dark

    task results;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results

    // ==========================================
    // Scenarios
    // ==========================================
    task t_normal;
        int         n;
        logic [7:0] a0;
        chk(multi === 1'b0 && status === 1'b1, "jumper 1-2 or idle light");
        jumper = 1'b1;
        cyc(4);
        chk(multi === 1'b1, "jumper 2-3 mode");
        jumper = 1'b0;
        cyc(4);
        a0 = acks;
        cmd_req = 1'b1;
        dark(n);
        chk(n >= 22 && n <= 24 && gate_on === 1'b1, "rise ack or gate on");
        cyc(240);
        chk(gate_on === 1'b1 && fault === 1'b0, "false trip without overvoltage");
        cmd_req = 1'b0;
        dark(n);
        chk(n >= 22 && n <= 24 && gate_on === 1'b0, "fall ack or gate off");
        chk(acks === a0 + 8'h02, "ack count");
    endtask : t_normal

    task t_sc_two;
        int n;
        n = 0;
        sc_comp = 1'b1;
        cmd_req = 1'b1;
        cyc(195);
        chk(gate_on === 1'b1, "tripped before sample point");
        n = 195;
        while (gate_on === 1'b1 && n < 300)
        begin
            cyc(1);
            n++;
        end
        chk(n <= 250 && gate_on === 1'b0, "turn-off deadline");
        chk(fault === 1'b1 && status === 1'b0, "fault report");
        sc_comp = 1'b0;
        cyc(HOLD - 100);
        chk(gate_on === 1'b0 && status === 1'b0, "gate or light during hold");
        cyc(150);
        chk(fault === 1'b0 && status === 1'b1, "hold end");
        cmd_req = 1'b0;
        cyc(30);
    endtask : t_sc_two

    task t_sc_multi;
        jumper = 1'b1;
        cyc(4);
        sc_comp = 1'b1;
        cmd_req = 1'b1;
        cyc(260);
        chk(gate_on === 1'b1, "gate dropped in multilevel");
        chk(fault === 1'b1 && status === 1'b0, "multilevel report");
        sc_comp = 1'b0;
        cmd_req = 1'b0;
        cyc(4);
        chk(gate_on === 1'b0, "host turn-off");
        cyc(HOLD);
        chk(fault === 1'b0 && status === 1'b1, "multilevel hold end");
        jumper = 1'b0;
        cyc(4);
    endtask : t_sc_multi

    task t_uvlo;
        uvlo = 1'b1;
        cyc(4);
        chk(status === 1'b0, "undervoltage light");
        cmd_req = 1'b1;
        cyc(10);
        chk(gate_on === 1'b0, "undervoltage gate");
        cmd_req = 1'b0;
        cyc(4);
        uvlo = 1'b0;
        cyc(30);
        chk(status === 1'b1 && fault === 1'b0, "recovery");
    endtask : t_uvlo

    // ==========================================
    // Main sequence and hang guard
    // ==========================================
    initial
    begin
        repeat (8) @(posedge clk_sys_in);
        #1;
        rstn_in = 1'b1;
        cyc(6);
        t_normal();
        $display("t_normal done");
        t_sc_two();
        $display("t_sc_two done");
        t_sc_multi();
        $display("t_sc_multi done");
        t_uvlo();
        $display("t_uvlo done");
        results();
    end

    // Ceiling sits well above the roughly two thousand cycles the tests need
    always @(posedge clk_sys_in)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            err_total++;
            $display("[FAIL] %0t ns timeout", $time);
            results();
        end
    end
endmodule : gate_driver_fault_feedback_tb
